// >>> cts_ctrl.sv
// supply-control, mode, status and ringing-suppression logic of a CAN FD transceiver
// assumes pins arrive asynchronously; the wake log drain may stall
`include "cts_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cts_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // output stage is a register, so the memory holds the words behind it
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count_r != '0) && (!out_valid || out_ready);

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rptr_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

module cts_ctrl #(
  parameter int LOCK_FILTER_CYC = `CTS_LOCK_FILTER_CYC,
  parameter int GTS_CYC = `CTS_GTS_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic txd_pin,
  input wire logic txd_pin_drv,
  input wire logic en_pin,
  input wire logic en_pin_drv,
  input wire logic standby_select_n,
  input wire logic standby_select_n_drv,
  input wire logic supply_control_lock_in,
  input wire logic lock_in_drv,
  input wire logic wake_pin,
  input wire logic bus_wake_pattern,
  input wire logic bus_rx_level,
  input wire logic vio_valid,
  input wire logic vsup_uv,
  output logic rxd_out,
  output logic status_alert_out_n,
  output logic status_alert_oe,
  output logic supply_control_out,
  output logic supply_control_oe,
  output logic drv_dominant,
  output logic drv_active_rec,
  output logic [2:0] mode_out,
  output logic [4:0] wake_evt_data,
  output logic wake_evt_valid,
  input wire logic wake_evt_ready
);
  cts_pkg::cts_pins_s pin_raw;
  cts_pkg::cts_pins_s pin_s1;
  cts_pkg::cts_pins_s pin_s2;
  logic wake_s3;
  logic txd_s3;
  cts_pkg::cts_mode_e mode_r;
  cts_pkg::cts_mode_e mode_nxt;
  cts_pkg::cts_mode_e pin_mode;
  logic [`CTS_CNT_W-1:0] gts_cnt_r;
  logic [`CTS_CNT_W-1:0] lock_cnt_r;
  logic lock_latched_r;
  logic lock_ack_r;
  logic pwron_r;
  logic wake_rq_r;
  logic local_edge;
  logic wake_ev;
  logic evt_pend_r;
  cts_pkg::cts_evt_s evt_r;
  logic evt_ready;
  logic [`CTS_CNT_W-1:0] ar_cnt_r;
  logic txd_rise;
  logic leave_silent;

  // undriven pins fold to their pulled level before the synchroniser
  always_comb begin
    pin_raw.txd = txd_pin | ~txd_pin_drv;
    pin_raw.en = en_pin & en_pin_drv;
    pin_raw.stb_n = standby_select_n & standby_select_n_drv;
    pin_raw.lock = supply_control_lock_in & lock_in_drv;
    pin_raw.wake = wake_pin;
    pin_raw.bus_wake = bus_wake_pattern;
    pin_raw.bus_level = bus_rx_level;
    pin_raw.vio_ok = vio_valid;
    pin_raw.vsup_uv = vsup_uv;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_s1 <= '{txd: 1'b1, stb_n: 1'b0, bus_level: 1'b1, default: 1'b0};
      pin_s2 <= '{txd: 1'b1, stb_n: 1'b0, bus_level: 1'b1, default: 1'b0};
      wake_s3 <= 1'b0;
      txd_s3 <= 1'b1;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      wake_s3 <= pin_s2.wake;
      txd_s3 <= pin_s2.txd;
    end
  end

  assign local_edge = pin_s2.wake ^ wake_s3;
  assign txd_rise = pin_s2.txd & ~txd_s3;

  // mode select from enable and standby-select
  always_comb begin
    unique case ({pin_s2.en, pin_s2.stb_n})
      2'b11: pin_mode = cts_pkg::CTS_NORMAL;
      2'b01: pin_mode = cts_pkg::CTS_SILENT;
      2'b10: pin_mode = cts_pkg::CTS_GTS;
      2'b00: pin_mode = cts_pkg::CTS_STANDBY;
    endcase
  end

  assign wake_ev = (local_edge | pin_s2.bus_wake) && (mode_r == cts_pkg::CTS_STANDBY ||
    mode_r == cts_pkg::CTS_GTS || mode_r == cts_pkg::CTS_SLEEP);

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      cts_pkg::CTS_SLEEP: begin
        if (wake_ev) begin
          mode_nxt = cts_pkg::CTS_STANDBY;
        end else if (pin_s2.stb_n) begin
          mode_nxt = pin_mode;
        end
      end
      cts_pkg::CTS_GTS: begin
        if (wake_ev) begin
          mode_nxt = cts_pkg::CTS_STANDBY;
        end else if (pin_mode != cts_pkg::CTS_GTS) begin
          mode_nxt = pin_mode;
        end else if (gts_cnt_r == `CTS_CNT_W'(GTS_CYC - 1)) begin
          mode_nxt = cts_pkg::CTS_SLEEP;
        end
      end
      default: mode_nxt = pin_mode;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mode_r <= cts_pkg::CTS_STANDBY;
      gts_cnt_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      if (mode_r == cts_pkg::CTS_GTS && mode_nxt == cts_pkg::CTS_GTS) begin
        gts_cnt_r <= gts_cnt_r + 1'b1;
      end else begin
        gts_cnt_r <= '0;
      end
    end
  end

  // lock filter: a level differing from the latch must persist the whole count
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lock_cnt_r <= '0;
      lock_latched_r <= 1'b0;
    end else if (pin_s2.vsup_uv) begin
      lock_cnt_r <= '0;
      lock_latched_r <= 1'b0;
    end else if (mode_r == cts_pkg::CTS_SILENT && pin_s2.lock != lock_latched_r) begin
      if (lock_cnt_r == `CTS_CNT_W'(LOCK_FILTER_CYC - 1)) begin
        lock_cnt_r <= '0;
        lock_latched_r <= pin_s2.lock;
      end else begin
        lock_cnt_r <= lock_cnt_r + 1'b1;
      end
    end else begin
      lock_cnt_r <= '0;
    end
  end

  assign leave_silent = mode_r == cts_pkg::CTS_SILENT && mode_nxt != cts_pkg::CTS_SILENT;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lock_ack_r <= 1'b0;
    end else if (leave_silent) begin
      lock_ack_r <= 1'b0;
    end else if (mode_r == cts_pkg::CTS_SILENT && !pin_s2.vsup_uv &&
                 pin_s2.lock != lock_latched_r &&
                 lock_cnt_r == `CTS_CNT_W'(LOCK_FILTER_CYC - 1)) begin
      lock_ack_r <= 1'b1;
    end
  end

  // power-on and wake-request flags; a cold start counts as a wake
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pwron_r <= 1'b1;
      wake_rq_r <= 1'b1;
    end else begin
      if (pin_s2.vsup_uv) begin
        pwron_r <= 1'b1;
      end else if (mode_r == cts_pkg::CTS_NORMAL) begin
        pwron_r <= 1'b0;
      end
      if (wake_ev || pin_s2.vsup_uv) begin
        wake_rq_r <= 1'b1;
      end else if (mode_r == cts_pkg::CTS_NORMAL) begin
        wake_rq_r <= 1'b0;
      end
    end
  end

  // pin outputs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rxd_out <= 1'b0;
      status_alert_out_n <= 1'b1;
      status_alert_oe <= 1'b1;
      supply_control_out <= 1'b1;
      supply_control_oe <= 1'b1;
      mode_out <= cts_pkg::CTS_STANDBY;
    end else begin
      mode_out <= mode_r;
      if (!pin_s2.vio_ok) begin
        rxd_out <= 1'b0;
      end else if (mode_r == cts_pkg::CTS_NORMAL || mode_r == cts_pkg::CTS_SILENT) begin
        rxd_out <= pin_s2.bus_level;
      end else begin
        rxd_out <= ~wake_rq_r;
      end
      status_alert_out_n <= ~(lock_ack_r ||
        (pwron_r && mode_r == cts_pkg::CTS_SILENT) ||
        (wake_rq_r && mode_r == cts_pkg::CTS_STANDBY));
      status_alert_oe <= (mode_r != cts_pkg::CTS_SLEEP);
      supply_control_out <= (mode_r != cts_pkg::CTS_SLEEP) && !lock_latched_r;
      supply_control_oe <= (mode_r != cts_pkg::CTS_SLEEP);
    end
  end

  // transmitter with ringing suppression
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      drv_dominant <= 1'b0;
      drv_active_rec <= 1'b0;
      ar_cnt_r <= '0;
    end else begin
      drv_dominant <= (mode_r == cts_pkg::CTS_NORMAL) && !pin_s2.txd;
      if (mode_r == cts_pkg::CTS_NORMAL && txd_rise) begin
        drv_active_rec <= 1'b1;
        ar_cnt_r <= `CTS_CNT_W'(`CTS_ACTIVE_REC_CYC - 1);
      end else if (ar_cnt_r != '0 && pin_s2.txd && mode_r == cts_pkg::CTS_NORMAL) begin
        ar_cnt_r <= ar_cnt_r - 1'b1;
      end else begin
        drv_active_rec <= 1'b0;
        ar_cnt_r <= '0;
      end
    end
  end

  // wake event log; a full log holds the event pending until room frees
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      evt_pend_r <= 1'b1;
      evt_r <= '{src: cts_pkg::CTS_SRC_POWER, mode: cts_pkg::CTS_STANDBY};
    end else if (wake_ev && (!evt_pend_r || evt_ready)) begin
      evt_pend_r <= 1'b1;
      evt_r.src <= local_edge ? cts_pkg::CTS_SRC_LOCAL : cts_pkg::CTS_SRC_BUS;
      evt_r.mode <= mode_r;
    end else if (evt_ready) begin
      evt_pend_r <= 1'b0;
    end
  end

  cts_fifo #(.WIDTH($bits(cts_pkg::cts_evt_s)), .DEPTH(`CTS_FIFO_DEPTH)) u_log (
    .mclk(mclk),
    .reset(reset),
    .in_data(evt_r),
    .in_valid(evt_pend_r),
    .in_ready(evt_ready),
    .out_data(wake_evt_data),
    .out_valid(wake_evt_valid),
    .out_ready(wake_evt_ready)
  );

  // checks
  logic [`CTS_CNT_W-1:0] ar_len_r;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ar_len_r <= '0;
    end else begin
      ar_len_r <= drv_active_rec ? ar_len_r + 1'b1 : '0;
    end
  end

  sequence s_wake_in_sleep;
    mode_r == cts_pkg::CTS_SLEEP && local_edge && !lock_latched_r;
  endsequence

  sequence s_powered_up;
    mode_r == cts_pkg::CTS_STANDBY ##1 supply_control_out && supply_control_oe;
  endsequence

  a_txd_float: assert property (@(posedge mclk) disable iff (reset)
    (!txd_pin_drv)[*3] |=> !drv_dominant) else $error("floating txd drove dominant");
  a_sleep_alert: assert property (@(posedge mclk) disable iff (reset)
    mode_r == cts_pkg::CTS_SLEEP |=> !status_alert_oe) else $error("alert driven in sleep");
  a_sleep_supply: assert property (@(posedge mclk) disable iff (reset)
    mode_r == cts_pkg::CTS_SLEEP |=> !supply_control_oe && !supply_control_out)
    else $error("supply control driven in sleep");
  a_supply_on: assert property (@(posedge mclk) disable iff (reset)
    mode_r != cts_pkg::CTS_SLEEP && !lock_latched_r |=> supply_control_out)
    else $error("supply control off while enabled");
  a_lock_silent: assert property (@(posedge mclk) disable iff (reset)
    $changed(lock_latched_r) && lock_latched_r |-> $past(mode_r) == cts_pkg::CTS_SILENT)
    else $error("lock set outside silent mode");
  a_lock_filter: assert property (@(posedge mclk) disable iff (reset)
    $changed(lock_latched_r) && !$past(pin_s2.vsup_uv) |->
    $past(lock_cnt_r) == `CTS_CNT_W'(LOCK_FILTER_CYC - 1))
    else $error("lock accepted before filter time");
  a_lock_ack: assert property (@(posedge mclk) disable iff (reset)
    $changed(lock_ack_r) && lock_ack_r && mode_r == cts_pkg::CTS_SILENT
    |=> !status_alert_out_n) else $error("lock change not acknowledged");
  a_ack_release: assert property (@(posedge mclk) disable iff (reset)
    mode_r != cts_pkg::CTS_SILENT && $past(mode_r) == cts_pkg::CTS_SILENT |-> !lock_ack_r)
    else $error("lock indication kept after leaving silent");
  a_uv_unlock: assert property (@(posedge mclk) disable iff (reset)
    pin_s2.vsup_uv |=> !lock_latched_r) else $error("lock kept through undervoltage");
  a_wake_power: assert property (@(posedge mclk) disable iff (reset)
    s_wake_in_sleep |=> s_powered_up) else $error("wake did not power up node");
  a_active_rec_len: assert property (@(posedge mclk) disable iff (reset)
    ar_len_r <= `CTS_CNT_W'(`CTS_ACTIVE_REC_CYC)) else $error("active recessive too long");
  a_active_rec_start: assert property (@(posedge mclk) disable iff (reset)
    mode_r == cts_pkg::CTS_NORMAL && txd_rise |=> drv_active_rec && !drv_dominant)
    else $error("no active recessive after edge");
  a_rxd_wake: assert property (@(posedge mclk) disable iff (reset)
    wake_rq_r && pin_s2.vio_ok && mode_r == cts_pkg::CTS_STANDBY |=> !rxd_out)
    else $error("rxd not low on wake");
endmodule

`default_nettype wire

// >>> cts_defines.svh
// constants of the transceiver supply-control block
// assumes one 200 MHz clock and pins sampled through two flip-flops
//
// Contract
// - unconnected transmit input counts as recessive; never drives bus dominant
// - receive output idles high once the I/O supply is valid
// - power-on or wake-up pulls the receive output low
// - active-low status output carries flags, high when none is present
// - status output goes high-impedance in sleep mode
// - mode comes from enable and standby-select, undriven inputs read low
// - undriven standby-select reads low, avoiding spurious power-up
// - after cold start the lock defaults low, supply control enabled
// - lock input acts only in silent mode; high past filter disables supply
// - lock low past filter time in silent mode re-enables supply control
// - latched lock state survives core and I/O supply loss and mode changes
// - battery undervoltage discards the latched lock, back to enabled
// - lock state change in silent mode drives the status output low
// - entering normal, standby, go-to-sleep or sleep releases the lock indication
// - supply control output is active in every mode but sleep, per lock
// - entering sleep switches supply control off into high impedance
// - bus or local wake starts power-up by driving supply control high; with the lock latched the code keeps it low
// - local wake input registers a wake on either edge
// - after transmit rising edge driver holds low-impedance recessive a while
// - after the active phase the driver goes passive, outputs high impedance
// - active recessive phase ends within 530 ns of the transmit rising edge
`ifndef CTS_DEFINES_SVH
`define CTS_DEFINES_SVH

`define CTS_CLK_PERIOD_NS 5
`define CTS_ACTIVE_REC_TIME_NS 530
`define CTS_SYNC_LAT 3
// longest time rounds down; the pin synchroniser latency is taken off
`define CTS_ACTIVE_REC_CYC \
  ((`CTS_ACTIVE_REC_TIME_NS / `CTS_CLK_PERIOD_NS) - `CTS_SYNC_LAT)
`define CTS_LOCK_FILTER_CYC 16
`define CTS_GTS_CYC 64
`define CTS_FIFO_DEPTH 8
`define CTS_CNT_W 8

`endif

// >>> cts_pkg.sv
// types shared by the supply-control block
// assumes nothing of its surroundings
package cts_pkg;

  typedef enum logic [2:0] {
    CTS_STANDBY = 3'h0,
    CTS_GTS     = 3'h1,
    CTS_SLEEP   = 3'h3,
    CTS_SILENT  = 3'h2,
    CTS_NORMAL  = 3'h6
  } cts_mode_e;

  typedef struct packed {
    logic txd;
    logic en;
    logic stb_n;
    logic lock;
    logic wake;
    logic bus_wake;
    logic bus_level;
    logic vio_ok;
    logic vsup_uv;
  } cts_pins_s;

  typedef enum logic [1:0] {
    CTS_SRC_POWER = 2'h0,
    CTS_SRC_LOCAL = 2'h1,
    CTS_SRC_BUS   = 2'h2
  } cts_src_e;

  typedef struct packed {
    cts_src_e src;
    cts_mode_e mode;
  } cts_evt_s;

endpackage

// >>> cts_mcu_model.sv
// controller-side model: mode, transmit and lock pins plus the drain of the wake log
// assumes the bench sets its request inputs just after the rising edge of mclk
`timescale 1ns/1ps
`default_nettype none
module cts_mcu_model (
  input wire logic mclk,
  input wire logic [1:0] mode_req,
  input wire logic mode_float,
  input wire logic txd_req,
  input wire logic txd_float,
  input wire logic lock_req,
  input wire logic ready_stall,
  input wire logic slow,
  input wire logic status_n,
  input wire logic [4:0] evt_data,
  input wire logic evt_valid,
  output logic txd_pin,
  output logic txd_pin_drv,
  output logic en_pin,
  output logic en_pin_drv,
  output logic standby_select_n,
  output logic standby_select_n_drv,
  output logic lock_pin,
  output logic lock_pin_drv,
  output logic evt_ready,
  output int taken,
  output logic [4:0] last_evt
);
  logic tick;
  initial begin
    tick = 1'b0;
    taken = 0;
    last_evt = 5'h00;
    txd_pin = 1'b1;
    txd_pin_drv = 1'b0;
    en_pin = 1'b0;
    en_pin_drv = 1'b0;
    standby_select_n = 1'b0;
    standby_select_n_drv = 1'b0;
    lock_pin = 1'b0;
    lock_pin_drv = 1'b1;
    evt_ready = 1'b0;
  end
  always @(posedge mclk) begin
    if (evt_valid === 1'b1 && evt_ready === 1'b1) begin
      taken = taken + 1;
      last_evt = evt_data;
    end
    // read the requests after the bench has moved them, never in the same step
    #2;
    tick = ~tick;
    // slow drain takes a word only every other cycle
    evt_ready = ~ready_stall & (~slow | tick);
    // released lines show a pattern that changes every cycle
    txd_pin_drv = ~txd_float;
    txd_pin = txd_float ? ~txd_pin : txd_req;
    en_pin_drv = ~mode_float;
    standby_select_n_drv = ~mode_float;
    en_pin = mode_float ? ~en_pin : mode_req[1];
    standby_select_n = mode_float ? ~standby_select_n : mode_req[0];
    // lock level only moves while the status line reads high
    if (lock_req !== lock_pin && status_n !== 1'b0) begin
      lock_pin = lock_req;
    end
  end
endmodule
`default_nettype wire

// >>> can_transceiver_supply_control_bench.sv
// bench of the supply-control block: modes, transmit, lock latch, sleep and wake log
// assumes the controller model of cts_mcu_model.sv and a 200 MHz mclk
`timescale 1ns/1ps
`default_nettype none
module can_transceiver_supply_control_bench;
  logic mclk, reset, wake_pin, bus_wake_pattern, bus_rx_level, vio_valid, vsup_uv;
  logic [1:0] mode_req;
  logic mode_float, txd_req, txd_float, lock_req, ready_stall, slow;
  logic txd_pin, txd_drv, en_pin, en_drv, stb_n, stb_drv, lock_pin, lock_drv, evt_ready;
  logic rxd, st_n, st_oe, sup, sup_oe, drv_dom, drv_rec, evt_valid;
  logic [2:0] mode;
  logic [4:0] evt_data, last_evt;
  int taken, num_errors, n_checks, cnt, base;
  logic [31:0] rng;

  cts_ctrl #(.LOCK_FILTER_CYC(4), .GTS_CYC(8)) u_cts_ctrl (
    .mclk(mclk), .reset(reset), .txd_pin(txd_pin), .txd_pin_drv(txd_drv),
    .en_pin(en_pin), .en_pin_drv(en_drv), .standby_select_n(stb_n),
    .standby_select_n_drv(stb_drv), .supply_control_lock_in(lock_pin),
    .lock_in_drv(lock_drv), .wake_pin(wake_pin), .bus_wake_pattern(bus_wake_pattern),
    .bus_rx_level(bus_rx_level), .vio_valid(vio_valid), .vsup_uv(vsup_uv),
    .rxd_out(rxd), .status_alert_out_n(st_n), .status_alert_oe(st_oe),
    .supply_control_out(sup), .supply_control_oe(sup_oe), .drv_dominant(drv_dom),
    .drv_active_rec(drv_rec), .mode_out(mode), .wake_evt_data(evt_data),
    .wake_evt_valid(evt_valid), .wake_evt_ready(evt_ready));

  cts_mcu_model u_cts_mcu_model (
    .mclk(mclk), .mode_req(mode_req), .mode_float(mode_float), .txd_req(txd_req),
    .txd_float(txd_float), .lock_req(lock_req), .ready_stall(ready_stall), .slow(slow),
    .status_n(st_oe ? st_n : 1'b1), .evt_data(evt_data), .evt_valid(evt_valid),
    .txd_pin(txd_pin), .txd_pin_drv(txd_drv), .en_pin(en_pin), .en_pin_drv(en_drv),
    .standby_select_n(stb_n), .standby_select_n_drv(stb_drv), .lock_pin(lock_pin),
    .lock_pin_drv(lock_drv), .evt_ready(evt_ready), .taken(taken), .last_evt(last_evt));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic cts_pkg::cts_mode_e exp_mode(input logic [1:0] p);
    case (p)
      2'h3: return cts_pkg::CTS_NORMAL;
      2'h1: return cts_pkg::CTS_SILENT;
      2'h2: return cts_pkg::CTS_GTS;
      default: return cts_pkg::CTS_STANDBY;
    endcase
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic done(input string what);
    $display("test %s finished, mismatches so far %0d", what, num_errors);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wait_mode(input logic [2:0] m);
    cnt = 0;
    while (mode !== m) begin
      step(1);
      cnt++;
      if (cnt > 60) begin
        num_errors++;
        $display("BAD mode expected %0h seen %0h", m, mode);
        end_of_test();
      end
    end
    n_checks++;
  endtask

  task automatic set_mode(input logic [1:0] p);
    mode_req = p;
    wait_mode(exp_mode(p));
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("BAD run length expected 20000 cycles at most seen more");
    end_of_test();
  end

  initial begin
    reset = 1'b1;
    wake_pin = 1'b0;
    bus_wake_pattern = 1'b0;
    bus_rx_level = 1'b1;
    vio_valid = 1'b1;
    vsup_uv = 1'b0;
    mode_req = 2'h0;
    mode_float = 1'b1;
    txd_req = 1'b1;
    txd_float = 1'b1;
    lock_req = 1'b0;
    ready_stall = 1'b1;
    slow = 1'b0;
    rng = 32'h8B04;
    step(3);
    chk("supply", 8'h01, 8'(sup));
    chk("status", 8'h01, 8'(st_n));
    step(3);
    reset = 1'b0;
    step(8);
    chk("mode", 8'(cts_pkg::CTS_STANDBY), 8'(mode));
    chk("rxd", 8'h00, 8'(rxd));
    chk("evt", 8'({1'b1, cts_pkg::CTS_SRC_POWER, cts_pkg::CTS_STANDBY}),
      8'({evt_valid, evt_data}));
    ready_stall = 1'b0;
    step(4);
    chk("taken", 8'h01, 8'(taken));
    done("reset");
    mode_float = 1'b0;
    set_mode(2'h3);
    chk("status", 8'h01, 8'(st_n));
    for (int i = 0; i < 8; i++) begin
      rng = xorshift(rng);
      bus_rx_level = rng[0];
      step(6);
      chk("rxd", 8'(rng[0]), 8'(rxd));
    end
    bus_rx_level = 1'b1;
    vio_valid = 1'b0;
    step(6);
    chk("rxd_no_vio", 8'h00, 8'(rxd));
    vio_valid = 1'b1;
    step(6);
    chk("rxd_vio", 8'h01, 8'(rxd));
    txd_float = 1'b0;
    txd_req = 1'b0;
    step(6);
    chk("dominant", 8'h01, 8'(drv_dom));
    txd_req = 1'b1;
    cnt = 0;
    for (int i = 0; i < 200; i++) begin
      step(1);
      if (drv_rec === 1'b1) cnt++;
    end
    chk("active_rec_cycles", 8'(530 / 5 - 3), 8'(cnt));
    chk("passive", 8'h00, 8'({drv_dom, drv_rec}));
    txd_float = 1'b1;
    cnt = 0;
    for (int i = 0; i < 40; i++) begin
      step(1);
      if (drv_dom !== 1'b0) cnt++;
    end
    chk("float_dominant", 8'h00, 8'(cnt));
    done("transmit");
    set_mode(2'h1);
    chk("status", 8'h01, 8'(st_n));
    lock_req = 1'b1;
    step(2);
    lock_req = 1'b0;
    step(20);
    chk("supply", 8'h01, 8'(sup));
    lock_req = 1'b1;
    step(20);
    chk("supply", 8'h00, 8'(sup));
    chk("status", 8'h00, 8'(st_n));
    set_mode(2'h3);
    step(2);
    chk("status", 8'h01, 8'(st_n));
    chk("supply", 8'h00, 8'(sup));
    set_mode(2'h0);
    lock_req = 1'b0;
    step(20);
    chk("supply", 8'h00, 8'(sup));
    set_mode(2'h1);
    step(20);
    chk("supply", 8'h01, 8'(sup));
    chk("status", 8'h00, 8'(st_n));
    set_mode(2'h3);
    set_mode(2'h1);
    lock_req = 1'b1;
    step(20);
    chk("supply", 8'h00, 8'(sup));
    set_mode(2'h3);
    lock_req = 1'b0;
    step(4);
    vsup_uv = 1'b1;
    step(6);
    vsup_uv = 1'b0;
    step(6);
    chk("supply", 8'h01, 8'(sup));
    done("lock");
    mode_req = 2'h2;
    wait_mode(cts_pkg::CTS_SLEEP);
    step(2);
    chk("oe", 8'h00, 8'({st_oe, sup_oe}));
    mode_req = 2'h0;
    ready_stall = 1'b1;
    step(4);
    wake_pin = 1'b1;
    wait_mode(cts_pkg::CTS_STANDBY);
    step(6);
    chk("supply", 8'h03, 8'({sup, sup_oe}));
    chk("rxd", 8'h00, 8'(rxd));
    chk("evt", 8'({1'b1, cts_pkg::CTS_SRC_LOCAL, cts_pkg::CTS_SLEEP}),
      8'({evt_valid, evt_data}));
    done("sleep");
    base = taken;
    for (int i = 0; i < 12; i++) begin
      wake_pin = ~wake_pin;
      step(8);
    end
    slow = 1'b1;
    ready_stall = 1'b0;
    step(60);
    // one word in the output stage, eight in the log, one pending; the rest are dropped
    chk("drained", 8'h0A, 8'(taken - base));
    chk("empty", 8'h00, 8'(evt_valid));
    bus_wake_pattern = 1'b1;
    step(6);
    bus_wake_pattern = 1'b0;
    step(30);
    chk("bus_wake", 8'(cts_pkg::CTS_SRC_BUS), 8'(last_evt[4:3]));
    done("wake log");
    end_of_test();
  end
endmodule
`default_nettype wire
